// File: retry_defs.svh
// retry sequencer constants: offsets, reset values, timing
// assumes a 20 MHz mclk
`ifndef RETRY_DEFS_SVH
`define RETRY_DEFS_SVH
`define OFS_CLASS_SEL   3'h0
`define OFS_RETRY_CNT   3'h1
`define OFS_WAIT_TIME   3'h2
`define OFS_SUCCESS     3'h3
`define OFS_COAST_TIME  3'h4
`define OFS_STATUS      3'h5
`define RST_CLASS_SEL   3'h0
`define RST_RETRY_CNT   7'h00
`define RST_WAIT_TIME   12'h00A
`define RST_COAST_TIME  14'h270F
`define COAST_OFF       14'h270F
`define SEL_MAX         3'h5
`define CNT_LOW_MAX     7'h0A
`define CNT_HI_MIN      7'h65
`define CNT_HI_MAX      7'h6E
`define CNT_HI_BASE     7'h64
`define SUCCESS_MULT    16'h0004
`define CLK_PERIOD_NS   50
`define WAIT_UNIT_NS    100000000
`define WAIT_UNIT_CYC   (`WAIT_UNIT_NS / `CLK_PERIOD_NS)
`endif

// File: retry_pkg.sv
// retry sequencer types
// assumes nothing beyond the compiler
package retry_pkg;
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_WAIT   = 5'h02,
        ST_RUN    = 5'h04,
        ST_TRIP   = 5'h08,
        ST_EXCESS = 5'h10
    } seq_state_t;
    typedef enum logic [4:0] {
        overcurrent_accel_trip = 5'h00,
        overcurrent_const_trip = 5'h01,
        overcurrent_decel_trip = 5'h02,
        overvoltage_accel_trip = 5'h03,
        overvoltage_const_trip = 5'h04,
        overvoltage_decel_trip = 5'h05,
        motor_thermal_trip     = 5'h06,
        drive_thermal_trip     = 5'h07,
        brake_circuit_trip     = 5'h08,
        earth_fault_trip       = 5'h09,
        usb_comm_trip          = 5'h0A,
        external_thermal_trip  = 5'h0B,
        stall_trip             = 5'h0C,
        option_trip            = 5'h0D,
        comm_option_trip       = 5'h0E,
        param_storage_fault    = 5'h0F,
        brake_seq_trip_a       = 5'h10,
        brake_seq_trip_b       = 5'h11,
        brake_seq_trip_c       = 5'h12,
        brake_seq_trip_d       = 5'h13,
        input_phase_trip       = 5'h14,
        retry_excess_fault     = 5'h15
    } fault_class_t;
endpackage

// File: retry_seq.sv
// fault retry sequencer for a motor drive
// assumes faults arrive as one-cycle pulses with a class code, register port on mclk
//
// Notes on behaviour
// - class select 0..5, reset 0; retry only faults retriable under it
// - 0 all; 1 overcurrent; 2 overvoltage; 3 both
// - 4 all but motor, drive and external thermal trips
// - 5 only accel and decel overcurrent
// - count 0 no retry; 1..10 retries, alarm quiet while retrying
// - count 101..110 gives setting minus 100 retries, alarm on while retrying
// - after wait time, clear fault and restart at starting frequency
// - wait 0.1..360 s, reset 1 s, zero acts as 0.1 s
// - failures beyond allowed count raise retry excess fault and trip
// - fault free over four waits: success count plus one, failures cleared
// - success count reads back; writing zero clears it
// - retry active flag high throughout retry operation
// - fault history keeps only the first fault of a retry error
// - retry fault reset keeps thermal and duty data
// - no retry when storage fault found at power on
// - unselected fault during wait abandons retry, fault stays shown
// - coast time not 9999: retry restart uses power failure restart
// - automatic restart sequence runs at each retry
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "retry_defs.svh"
module retry_seq #(
    parameter int unsigned TICK_CYCLES = `WAIT_UNIT_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // fault side
    input  wire logic        fault_valid,
    input  wire logic [4:0]  fault_code,
    input  wire logic        manual_reset,
    input  wire logic        pe_at_power_on,
    // drive control
    output logic             fault_reset,
    output logic             restart,
    output logic             restart_flying,
    output logic             tripped,
    output logic             alarm_out,
    output logic             retry_active_flag,
    output logic             retry_excess_fault,
    // fault history
    output logic             hist_wr,
    output logic      [4:0]  hist_code
);
    tick_if tb ();

    retry_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .mclk (mclk),
        .rst  (rst),
        .tb   (tb)
    );

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function automatic logic retriable(input logic [2:0] sel, input logic [4:0] code);
        logic oc;
        logic ov;
        logic th;
        oc = code <= 5'(retry_pkg::overcurrent_decel_trip);
        ov = code >= 5'(retry_pkg::overvoltage_accel_trip) && code <= 5'(retry_pkg::overvoltage_decel_trip);
        th = code == 5'(retry_pkg::motor_thermal_trip) || code == 5'(retry_pkg::drive_thermal_trip)
             || code == 5'(retry_pkg::external_thermal_trip);
        if (code > 5'(retry_pkg::input_phase_trip))
            return 1'b0;
        case (sel)
            3'h0: return 1'b1;
            3'h1: return oc;
            3'h2: return ov;
            3'h3: return oc | ov;
            3'h4: return !th;
            3'h5: return code == 5'(retry_pkg::overcurrent_accel_trip)
                         || code == 5'(retry_pkg::overcurrent_decel_trip);
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [6:0] allowed(input logic [6:0] s);
        if (s >= 7'h01 && s <= `CNT_LOW_MAX)
            return s;
        if (s >= `CNT_HI_MIN && s <= `CNT_HI_MAX)
            return 7'(s - `CNT_HI_BASE);
        return 7'h00;
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [2:0]  class_sel_r;
    logic [2:0]  class_sel_nxt;
    logic [6:0]  cnt_set_r;
    logic [6:0]  cnt_set_nxt;
    logic [11:0] wait_r;
    logic [11:0] wait_nxt;
    logic [13:0] coast_r;
    logic [13:0] coast_nxt;
    logic [15:0] success_r;
    logic [15:0] success_nxt;
    logic [15:0] rdata_nxt;
    logic        success_evt;

    always_comb begin
        class_sel_nxt = class_sel_r;
        cnt_set_nxt   = cnt_set_r;
        wait_nxt      = wait_r;
        coast_nxt     = coast_r;
        success_nxt   = success_r;
        rdata_nxt     = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                `OFS_CLASS_SEL:  class_sel_nxt = reg_wdata[2:0];
                `OFS_RETRY_CNT:  cnt_set_nxt = reg_wdata[6:0];
                `OFS_WAIT_TIME:  wait_nxt = reg_wdata[11:0];
                `OFS_SUCCESS:    if (reg_wdata == 16'h0000) success_nxt = 16'h0000;
                `OFS_COAST_TIME: coast_nxt = reg_wdata[13:0];
                default: ;
            endcase
        end
        if (success_evt)
            success_nxt = (reg_wr && reg_addr == `OFS_SUCCESS && reg_wdata == 16'h0000)
                          ? 16'h0001 : 16'(success_r + 16'h0001);
        if (reg_rd) begin
            case (reg_addr)
                `OFS_CLASS_SEL:  rdata_nxt = {13'h0000, class_sel_r};
                `OFS_RETRY_CNT:  rdata_nxt = {9'h000, cnt_set_r};
                `OFS_WAIT_TIME:  rdata_nxt = {4'h0, wait_r};
                `OFS_SUCCESS:    rdata_nxt = success_r;
                `OFS_COAST_TIME: rdata_nxt = {2'h0, coast_r};
                `OFS_STATUS:     rdata_nxt = status_word();
                default:         rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            class_sel_r <= `RST_CLASS_SEL;
            cnt_set_r   <= `RST_RETRY_CNT;
            wait_r      <= `RST_WAIT_TIME;
            coast_r     <= `RST_COAST_TIME;
            success_r   <= 16'h0000;
            reg_rdata   <= 16'h0000;
        end else begin
            class_sel_r <= class_sel_nxt;
            cnt_set_r   <= cnt_set_nxt;
            wait_r      <= wait_nxt;
            coast_r     <= coast_nxt;
            success_r   <= success_nxt;
            reg_rdata   <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // power-on storage fault catch
    // ----------------------------------------
    logic first_r;
    logic pe_lock_r;
    logic pe_lock_nxt;

    always_comb begin
        pe_lock_nxt = pe_lock_r;
        if (first_r && pe_at_power_on)
            pe_lock_nxt = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            first_r   <= 1'b1;
            pe_lock_r <= 1'b0;
        end else begin
            first_r   <= 1'b0;
            pe_lock_r <= pe_lock_nxt;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    retry_pkg::seq_state_t st_r;
    retry_pkg::seq_state_t st_nxt;
    logic [15:0] timer_r;
    logic [15:0] timer_nxt;
    logic [6:0]  fail_r;
    logic [6:0]  fail_nxt;
    logic [4:0]  code_r;
    logic [4:0]  code_nxt;
    logic        frst_nxt;
    logic        rstrt_nxt;
    logic        hwr_nxt;
    logic        sel_ok;
    logic        can_retry;
    logic [15:0] wait_eff;

    function automatic logic [15:0] status_word();
        return {st_r, fail_r, pe_lock_r, code_r[2:0]};
    endfunction

    assign sel_ok    = class_sel_r <= `SEL_MAX && retriable(class_sel_r, fault_code);
    assign can_retry = sel_ok && allowed(cnt_set_r) != 7'h00 && !pe_lock_r;
    assign wait_eff  = (wait_r == 12'h000) ? 16'h0001 : {4'h0, wait_r};
    assign success_evt = st_r == retry_pkg::ST_RUN && tb.tick && timer_r == 16'h0000 && !fault_valid;

    always_comb begin
        st_nxt    = st_r;
        timer_nxt = timer_r;
        fail_nxt  = fail_r;
        code_nxt  = code_r;
        frst_nxt  = 1'b0;
        rstrt_nxt = 1'b0;
        hwr_nxt   = 1'b0;
        case (st_r)
            retry_pkg::ST_IDLE: begin
                if (fault_valid) begin
                    code_nxt = fault_code;
                    hwr_nxt  = 1'b1;
                    if (can_retry) begin
                        st_nxt    = retry_pkg::ST_WAIT;
                        timer_nxt = 16'(wait_eff - 16'h0001);
                    end else begin
                        st_nxt = retry_pkg::ST_TRIP;
                    end
                end
            end
            retry_pkg::ST_WAIT: begin
                if (fault_valid && !sel_ok) begin
                    st_nxt   = retry_pkg::ST_TRIP;
                    code_nxt = fault_code;
                end else if (tb.tick) begin
                    if (timer_r == 16'h0000) begin
                        st_nxt    = retry_pkg::ST_RUN;
                        frst_nxt  = 1'b1;
                        rstrt_nxt = 1'b1;
                        timer_nxt = 16'(wait_eff * `SUCCESS_MULT);
                    end else begin
                        timer_nxt = 16'(timer_r - 16'h0001);
                    end
                end
            end
            retry_pkg::ST_RUN: begin
                if (fault_valid) begin
                    fail_nxt = 7'(fail_r + 7'h01);
                    if (fail_nxt > allowed(cnt_set_r)) begin
                        st_nxt = retry_pkg::ST_EXCESS;
                    end else if (!sel_ok || pe_lock_r) begin
                        st_nxt   = retry_pkg::ST_TRIP;
                        code_nxt = fault_code;
                    end else begin
                        st_nxt    = retry_pkg::ST_WAIT;
                        timer_nxt = 16'(wait_eff - 16'h0001);
                    end
                end else if (success_evt) begin
                    st_nxt   = retry_pkg::ST_IDLE;
                    fail_nxt = 7'h00;
                end else if (tb.tick) begin
                    timer_nxt = 16'(timer_r - 16'h0001);
                end
            end
            retry_pkg::ST_TRIP, retry_pkg::ST_EXCESS: begin
                if (manual_reset) begin
                    st_nxt   = retry_pkg::ST_IDLE;
                    fail_nxt = 7'h00;
                end
            end
            default: st_nxt = retry_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r        <= retry_pkg::ST_IDLE;
            timer_r     <= 16'h0000;
            fail_r      <= 7'h00;
            code_r      <= 5'h00;
            fault_reset <= 1'b0;
            restart     <= 1'b0;
            hist_wr     <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            timer_r     <= timer_nxt;
            fail_r      <= fail_nxt;
            code_r      <= code_nxt;
            fault_reset <= frst_nxt;
            restart     <= rstrt_nxt;
            hist_wr     <= hwr_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hist_code          = code_r;
    assign restart_flying     = restart && coast_r != `COAST_OFF;
    assign retry_active_flag  = st_r == retry_pkg::ST_WAIT || st_r == retry_pkg::ST_RUN;
    assign retry_excess_fault = st_r == retry_pkg::ST_EXCESS;
    assign tripped            = st_r == retry_pkg::ST_TRIP || st_r == retry_pkg::ST_EXCESS
                                || st_r == retry_pkg::ST_WAIT;
    assign alarm_out          = st_r == retry_pkg::ST_TRIP || st_r == retry_pkg::ST_EXCESS
                                || (retry_active_flag && cnt_set_r >= `CNT_HI_MIN);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_wait_entry: assert property (st_r == retry_pkg::ST_IDLE && fault_valid && can_retry
        |=> st_r == retry_pkg::ST_WAIT) else $error("retriable fault did not start wait");
    a_zero_count: assert property (st_r == retry_pkg::ST_IDLE && fault_valid
        && allowed(cnt_set_r) == 7'h00 |=> st_r == retry_pkg::ST_TRIP) else $error("retry with zero count");
    a_alarm_quiet: assert property (retry_active_flag && cnt_set_r <= `CNT_LOW_MAX
        |-> !alarm_out) else $error("alarm during quiet retry");
    a_alarm_loud: assert property (retry_active_flag && cnt_set_r >= `CNT_HI_MIN
        |-> alarm_out) else $error("alarm missing during retry");
    a_restart_pair: assert property ($rose(restart) |-> fault_reset
        && $past(st_r) == retry_pkg::ST_WAIT ##1 !restart)
        else $error("restart not paired with fault reset");
    a_reset_pulse: assert property (fault_reset |=> !fault_reset) else $error("fault reset held");
    a_excess_trip: assert property (st_r == retry_pkg::ST_RUN && fault_valid
        && 7'(fail_r + 7'h01) > allowed(cnt_set_r) |=> retry_excess_fault && alarm_out)
        else $error("excess not raised");
    a_success_cnt: assert property (success_evt && !reg_wr
        |=> success_r == $past(success_r) + 16'h0001 && fail_r == 7'h00) else $error("success not counted");
    a_hist_once: assert property (hist_wr |-> $past(st_r) == retry_pkg::ST_IDLE)
        else $error("history written mid retry");
    a_first_kept: assert property (st_r == retry_pkg::ST_RUN && fault_valid
        |=> !hist_wr && (hist_code == $past(hist_code) || st_r == retry_pkg::ST_TRIP))
        else $error("first fault overwritten");
    a_pe_block: assert property (pe_lock_r |-> !can_retry) else $error("retry after storage fault");
    a_abandon: assert property (st_r == retry_pkg::ST_WAIT && fault_valid && !sel_ok
        |=> st_r == retry_pkg::ST_TRIP ##1 !retry_active_flag) else $error("retry not abandoned");
    a_trip_hold: assert property (st_r == retry_pkg::ST_TRIP && !manual_reset
        |=> st_r == retry_pkg::ST_TRIP) else $error("trip left without reset");
endmodule

// File: retry_tick.sv
// divider giving a one-cycle enable every 0.1 s
// assumes mclk at 20 MHz, synchronous reset
`timescale 1ns/100ps
`include "retry_defs.svh"
module retry_tick #(
    parameter int unsigned TICK_CYCLES = `WAIT_UNIT_CYC
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // time base
    tick_if.src       tb
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 32'h00000001;
        if (cnt_r >= 32'(TICK_CYCLES - 1)) begin
            cnt_nxt  = 32'h00000000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r  <= 32'h00000000;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tb.tick = tick_r;
endmodule

// File: tb_fault_retry_sequencer.sv
// self-checking bench for the fault retry sequencer
// assumes retry_defs.svh, retry_pkg, tick_if, retry_tick and retry_seq compiled first
`timescale 1ns/100ps
`include "retry_defs.svh"
`include "tb_retry_helpers.svh"
module tb_fault_retry_sequencer;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int T = 4;
    logic        mclk;
    logic        rst;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        fault_valid;
    logic [4:0]  fault_code;
    logic        manual_reset;
    logic        pe_at_power_on;
    logic        fault_reset;
    logic        restart;
    logic        restart_flying;
    logic        tripped;
    logic        alarm_out;
    logic        retry_active_flag;
    logic        retry_excess_fault;
    logic        hist_wr;
    logic [4:0]  hist_code;
    int          fails     = 0;
    int          cmp_count = 0;
    int          succ_s    = 0;
    logic        pe_lock   = 1'b0;
    logic        rd_pend   = 1'b0;
    logic [13:0] coast_s   = `COAST_OFF;
    logic [31:0] lfsr_s    = 32'hC7428F87;
    note_t       exp_q[$];

    retry_seq #(.TICK_CYCLES(T)) dut_u (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_valid(fault_valid), .fault_code(fault_code),
        .manual_reset(manual_reset), .pe_at_power_on(pe_at_power_on), .fault_reset(fault_reset),
        .restart(restart), .restart_flying(restart_flying), .tripped(tripped), .alarm_out(alarm_out),
        .retry_active_flag(retry_active_flag), .retry_excess_fault(retry_excess_fault),
        .hist_wr(hist_wr), .hist_code(hist_code)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // read data monitor
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        note_t n;
        if (rd_pend) begin
            n = (exp_q.size() > 0) ? exp_q.pop_front() : note_t'{val: 16'hFFFF, mask: 16'h0000};
            `CHK(reg_rdata & n.mask, n.val);
        end
        rd_pend <= reg_rd;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic ok_class(input logic [2:0] s, input logic [4:0] c);
        logic oc;
        logic ov;
        logic th;
        oc = (c <= retry_pkg::overcurrent_decel_trip);
        ov = (c >= retry_pkg::overvoltage_accel_trip) && (c <= retry_pkg::overvoltage_decel_trip);
        th = (c == retry_pkg::motor_thermal_trip) || (c == retry_pkg::drive_thermal_trip) ||
             (c == retry_pkg::external_thermal_trip);
        case (s)
            3'h0: return c <= retry_pkg::input_phase_trip;
            3'h1: return oc;
            3'h2: return ov;
            3'h3: return oc || ov;
            3'h4: return (c <= retry_pkg::input_phase_trip) && !th;
            3'h5: return (c == retry_pkg::overcurrent_accel_trip) || (c == retry_pkg::overcurrent_decel_trip);
            default: return 1'b0;
        endcase
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back('{val: e & m, mask: m});
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
    endtask

    task automatic inject(input logic [4:0] c);
        @(posedge mclk);
        fault_valid <= 1'b1;
        fault_code  <= c;
        @(posedge mclk);
        fault_valid <= 1'b0;
        #1;
    endtask

    task automatic clear_trip();
        @(posedge mclk);
        manual_reset <= 1'b1;
        @(posedge mclk);
        manual_reset <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic wait_on(input int which, output int n);
        for (n = 1; n <= 400; n++) begin
            @(posedge mclk);
            #1;
            if (which == 0 && fault_reset === 1'b1) return;
            if (which == 1 && retry_active_flag === 1'b0) return;
        end
        fails++;
        $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask

    task automatic run_case(input logic [2:0] sel, input logic [4:0] c, input logic [6:0] cnt,
                            input logic [11:0] w, output int n1, output int n2);
        logic r;
        logic hi;
        hi = (cnt >= `CNT_HI_MIN) && (cnt <= `CNT_HI_MAX);
        r  = ok_class(sel, c) && !pe_lock && (hi || (cnt >= 7'h01 && cnt <= `CNT_LOW_MAX));
        n1 = 0;
        n2 = 0;
        reg_write(`OFS_CLASS_SEL, {13'h0000, sel});
        reg_write(`OFS_RETRY_CNT, {9'h000, cnt});
        reg_write(`OFS_WAIT_TIME, {4'h0, w});
        inject(c);
        `CHK(retry_active_flag, r);
        `CHK(tripped, 1'b1);
        `CHK(alarm_out, r ? hi : 1'b1);
        `CHK({hist_wr, hist_code}, {1'b1, c});
        if (r) begin
            wait_on(0, n1);
            `CHK({restart, tripped}, 2'b10);
            `CHK(restart_flying, coast_s != `COAST_OFF);
            wait_on(1, n2);
            succ_s++;
        end else begin
            `CHK(retry_excess_fault, 1'b0);
            clear_trip();
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n1;
        int n2;
        int we;
        logic [6:0] cnts [6];
        logic [11:0] waits [3];
        cnts  = '{7'h00, 7'h0B, 7'h64, 7'h6F, 7'h0A, 7'h6E};
        waits = '{12'h000, 12'h002, 12'h003};
        {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 3'h0, 16'h0000, 2'b00};
        {fault_valid, fault_code, manual_reset, pe_at_power_on} = {1'b0, 5'h00, 2'b00};
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        reg_write(3'h7, 16'hFFFF);
        reg_read(`OFS_CLASS_SEL, 16'h0000, 16'hFFFF);
        reg_read(`OFS_RETRY_CNT, 16'h0000, 16'hFFFF);
        reg_read(`OFS_WAIT_TIME, 16'h000A, 16'hFFFF);
        reg_read(`OFS_SUCCESS, 16'h0000, 16'hFFFF);
        reg_read(`OFS_COAST_TIME, 16'h270F, 16'hFFFF);
        reg_read(`OFS_STATUS, 16'h0800, 16'hFFF8);
        reg_read(3'h6, 16'h0000, 16'hFFFF);
        reg_read(3'h7, 16'h0000, 16'hFFFF);
        $display("test reset_values done");
        for (int s = 0; s <= 6; s++) begin
            lfsr_s  = lfsr_next(lfsr_s);
            coast_s = s[0] ? {1'b0, lfsr_s[12:0]} : `COAST_OFF;
            reg_write(`OFS_COAST_TIME, {2'b00, coast_s});
            for (int c = 0; c <= 21; c++) begin
                run_case(s[2:0], c[4:0], s[0] ? `CNT_HI_MIN : 7'h01, 12'h000, n1, n2);
            end
        end
        reg_read(`OFS_SUCCESS, succ_s[15:0], 16'hFFFF);
        $display("test class_table done");
        foreach (cnts[i]) begin
            run_case(3'h0, 5'h00, cnts[i], 12'h000, n1, n2);
        end
        $display("test count_settings done");
        foreach (waits[i]) begin
            run_case(3'h0, 5'h00, 7'h01, waits[i], n1, n2);
            we = (waits[i] == 12'h000) ? 1 : int'(waits[i]);
            `CHK(n1 >= (we - 1) * T && n1 <= we * T + 2, 1'b1);
            `CHK(n2 >= 4 * we * T + 1 && n2 <= (4 * we + 1) * T + 2, 1'b1);
        end
        $display("test wait_windows done");
        lfsr_s = lfsr_next(lfsr_s);
        reg_write(`OFS_SUCCESS, lfsr_s[15:0] | 16'h0001);
        reg_read(`OFS_SUCCESS, succ_s[15:0], 16'hFFFF);
        reg_write(`OFS_SUCCESS, 16'h0000);
        reg_read(`OFS_SUCCESS, 16'h0000, 16'hFFFF);
        $display("test success_clear done");
        reg_write(`OFS_RETRY_CNT, 16'h0002);
        reg_write(`OFS_WAIT_TIME, 16'h0003);
        inject(retry_pkg::overcurrent_accel_trip);
        for (int k = 1; k <= 3; k++) begin
            wait_on(0, n1);
            inject(retry_pkg::overcurrent_const_trip);
            `CHK(hist_wr, 1'b0);
            `CHK({retry_active_flag, retry_excess_fault}, (k < 3) ? 2'b10 : 2'b01);
        end
        `CHK({tripped, alarm_out, hist_code}, {2'b11, 5'h00});
        reg_read(`OFS_STATUS, 16'h8000, 16'hF800);
        inject(retry_pkg::overcurrent_accel_trip);
        `CHK({retry_excess_fault, hist_wr}, 2'b10);
        clear_trip();
        `CHK({retry_excess_fault, tripped}, 2'b00);
        $display("test retry_excess done");
        reg_write(`OFS_CLASS_SEL, 16'h0001);
        reg_write(`OFS_RETRY_CNT, 16'h0001);
        inject(retry_pkg::overcurrent_accel_trip);
        inject(retry_pkg::overcurrent_accel_trip);
        `CHK(retry_active_flag, 1'b1);
        inject(retry_pkg::motor_thermal_trip);
        `CHK({retry_active_flag, tripped, alarm_out, retry_excess_fault}, 4'b0110);
        reg_read(`OFS_STATUS, 16'h4000, 16'hF800);
        clear_trip();
        $display("test abandon_retry done");
        @(posedge mclk);
        pe_at_power_on <= 1'b1;
        rst            <= 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        pe_at_power_on <= 1'b0;
        pe_lock = 1'b1;
        `CHK({retry_active_flag, tripped, hist_wr, reg_rdata}, {3'b000, 16'h0000});
        reg_read(`OFS_STATUS, 16'h0008, 16'h0008);
        run_case(3'h0, retry_pkg::overcurrent_accel_trip, 7'h01, 12'h000, n1, n2);
        $display("test storage_fault_lock done");
        repeat (3) @(posedge mclk);
        `CHK(exp_q.size(), 0);
        wrap_up();
    end
endmodule

// File: tb_retry_helpers.svh
// bench helpers for the fault retry sequencer: compare macro and expected-value type
// assumes the including module declares fails and cmp_count
`ifndef TB_RETRY_HELPERS_SVH
`define TB_RETRY_HELPERS_SVH
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
typedef struct packed {
    logic [15:0] val;
    logic [15:0] mask;
} note_t;
`endif

// File: tick_if.sv
// carrier for the 0.1 s time base
// assumes one clock domain
`timescale 1ns/100ps
interface tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
